// *** vit_cpu_model.sv ***
// Processor core model: sees the request and acknowledges its vector.
// Assumes the controller's registered irq and vector outputs.
`timescale 1ns/1ps
module vit_cpu_model (
  // Clock, reset and control
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [3:0] delay_i,
  // Controller side
  input wire logic irq_i,
  input wire logic [2:0] vector_i,
  output logic ack_o,
  output logic [2:0] ack_vector_o
);
  logic [4:0] wait_q;
  // Holdoff of four cycles covers the two-cycle fall of irq after ack
  always_ff @(posedge core_clk_i) begin
    ack_o <= 1'b0;
    ack_vector_o <= ~ack_vector_o;
    if (reset_i) begin
      wait_q <= 5'h00;
      ack_vector_o <= 3'h0;
    end else if (wait_q != 5'h00) begin
      wait_q <= wait_q - 5'h01;
      if (wait_q == 5'h04) begin
        ack_o <= 1'b1;
        ack_vector_o <= vector_i;
      end
    end else if (irq_i && run_i) begin
      wait_q <= {1'b0, delay_i} + 5'h04;
    end
  end
endmodule // vit_cpu_model

// *** vit_free_timer.sv ***
// Twelve-bit free-running up counter at 1 MHz with two periodic taps.
// Assumes a core clock that is an integer multiple of the tick rate.
`timescale 1ns/1ps
module vit_free_timer #(
  parameter int unsigned CLK_HZ = vit_pkg::CORE_CLK_HZ,
  parameter int unsigned TICK_HZ = vit_pkg::TIMER_TICK_HZ
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Count and taps
  output logic [vit_pkg::TIMER_W-1:0] count_o,
  output logic tap_fast_o,
  output logic tap_slow_o
);
  import vit_pkg::*;

  localparam int unsigned DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned DIV_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
  localparam logic [TAP_FAST_BITS-1:0] FAST_LAST = '1;
  localparam logic [TAP_SLOW_BITS-1:0] SLOW_LAST = '1;

  // Divider needs a whole, nonzero ratio
  if (DIV < 1 || (CLK_HZ % TICK_HZ) != 0) begin : g_bad_div
    $error("vit_free_timer: clock must be a whole multiple of the tick rate");
  end

  logic [DIV_W-1:0] div_q;
  logic tick;

  assign tick = (div_q == DIV_LAST);

  // One-cycle tick enable every microsecond
  always_ff @(posedge core_clk_i) begin
    if (reset_i || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Counting never stops; readers only sample it [RQ3] [RQ9]
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      count_o <= '0;
    end else if (tick) begin
      count_o <= count_o + 1'b1;
    end
  end

  // Taps pulse as the low bits wrap [RQ4]
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tap_fast_o <= 1'b0;
      tap_slow_o <= 1'b0;
    end else begin
      tap_fast_o <= tick && (count_o[TAP_FAST_BITS-1:0] == FAST_LAST);
      tap_slow_o <= tick && (count_o[TAP_SLOW_BITS-1:0] == SLOW_LAST);
    end
  end

endmodule // vit_free_timer

// *** vit_irq_ctrl.sv ***
// Vectored interrupt controller with its free-running timer and GPIO edge logic.
// Assumes synchronous inputs, one 20 MHz clock and an Avalon-MM master.
//
// Operation
// RQ1 - Seven individually enabled sources, each presented with its own vector.
// RQ2 - Sources: bus reset, two timer taps, two endpoints, wake-up, GPIO.
// RQ3 - Twelve-bit up counter advancing once per microsecond from the core clock.
// RQ4 - Enabled timer taps interrupt every 128 us and every 1.024 ms.
// RQ5 - Endpoint interrupts only after their transaction has completed.
// RQ6 - Per-pin enable picks GPIO pins that may raise the shared request.
// RQ7 - Each GPIO pin has its own polarity setting.
// RQ8 - Polarity chooses rising or falling edge as the trigger.
// RQ9 - Timer count readable any time without disturbing counting.
// RQ10 - Start of PS/2 line activity raises an interrupt.
// RQ11 - Requests latch until acknowledged; need global and source enable. Here only GPIO needs both; the other sources have one enable bit each.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module vit_irq_ctrl #(
  parameter int unsigned P0_PINS = 8,
  parameter int unsigned P1_PINS = 2
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Event sources
  input wire logic usb_bus_reset_i,
  input wire logic ep0_done_i,
  input wire logic ep1_done_i,
  input wire logic wakeup_i,
  input wire logic [P0_PINS-1:0] port0_pins_i,
  input wire logic [P1_PINS-1:0] port1_pins_i,
  input wire logic ps2_clock_line_i,
  input wire logic ps2_data_line_i,
  // Processor side
  input wire logic irq_ack_i,
  input wire logic [2:0] irq_ack_vector_i,
  output logic irq_o,
  output logic [2:0] irq_vector_o
);
  import vit_pkg::*;

  // Port registers are one byte wide
  if (P0_PINS < 1 || P0_PINS > 8) begin : g_bad_p0
    $error("vit_irq_ctrl: port 0 must have 1 to 8 pins");
  end
  if (P1_PINS < 1 || P1_PINS > 8) begin : g_bad_p1
    $error("vit_irq_ctrl: port 1 must have 1 to 8 pins");
  end
  // Status is one byte and the vector three bits wide
  if (NUM_SRC < 1 || NUM_SRC > 8) begin : g_bad_src
    $error("vit_irq_ctrl: source count must be 1 to 8");
  end

  // Lowest set bit wins; returns its index
  // Bus reset and PS/2 start are therefore served first
  function automatic logic [2:0] pick_vector(input vit_src_t req);
    logic [2:0] v;
    v = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = 3'(i);
      end
    end
    return v;
  endfunction

  // Edge selected by polarity: 1 means rising, 0 falling
  function automatic logic pin_edge(input logic cur, input logic prev, input logic pol);
    return pol ? (cur && !prev) : (!cur && prev);
  endfunction

  // Aligned access to one register index
  function automatic logic reg_hit(input vit_bus_req_t r, input logic [7:0] idx);
    return r.aligned && (r.index == idx);
  endfunction

  // Timer
  // Taps are one-cycle pulses that set pending directly
  logic [TIMER_W-1:0] timer_count;
  logic tap_fast;
  logic tap_slow;

  vit_free_timer #(
    .CLK_HZ(CORE_CLK_HZ),
    .TICK_HZ(TIMER_TICK_HZ)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .count_o(timer_count),
    .tap_fast_o(tap_fast),
    .tap_slow_o(tap_slow)
  );

  // Registers
  logic [7:0] port0_en_q;
  logic [7:0] port1_en_q;
  logic [7:0] port0_pol_q;
  logic [7:0] port1_pol_q;
  logic [7:0] global_en_q;
  logic [7:0] endpoint_en_q;
  logic [7:0] timer_high_hold_q;
  vit_src_t pend_q;
  vit_src_t pend_set;
  vit_src_t pend_clr;
  vit_src_t src_en;
  vit_src_t live;

  // Bus slave
  vit_bus_state_t bus_state_q;
  vit_bus_req_t req;
  logic bus_take;
  logic bus_mapped;
  logic [7:0] rd_byte;
  logic rd_capture;
  logic wr_take;
  vit_src_t status_shown_q;

  assign req.read = avs_read_i;
  assign req.write = avs_write_i;
  assign req.index = avs_address_i[9:2];
  assign req.aligned = (avs_address_i[1:0] == 2'b00);
  assign req.wdata = avs_writedata_i[7:0];

  // Request is taken on the edge where waitrequest is seen low
  assign bus_take = (bus_state_q == VIT_BUS_ANSWER) && (req.read || req.write);
  // Read data, timer high byte and status snapshot are all captured as the
  // request is first seen, one edge before the take, so they agree
  assign rd_capture = (bus_state_q == VIT_BUS_IDLE) && req.read;
  // Byte lane 0 off leaves the register untouched
  assign wr_take = bus_take && req.write && req.aligned && avs_byteenable_i[0];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bus_state_q <= VIT_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end else begin
      case (bus_state_q)
        VIT_BUS_IDLE: begin
          if (req.read || req.write) begin
            bus_state_q <= VIT_BUS_ANSWER;
            avs_waitrequest_o <= 1'b0;
          end
        end
        VIT_BUS_ANSWER: begin
          bus_state_q <= VIT_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state_q <= VIT_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_byte = 8'h00;
    bus_mapped = req.aligned;
    case (req.index)
      REG_PORT0_IRQ_ENABLE: rd_byte = port0_en_q;
      REG_PORT1_IRQ_ENABLE: rd_byte = port1_en_q;
      REG_PORT0_IRQ_POLARITY: rd_byte = port0_pol_q;
      REG_PORT1_IRQ_POLARITY: rd_byte = port1_pol_q;
      REG_GLOBAL_IRQ_ENABLE: rd_byte = global_en_q;
      REG_ENDPOINT_IRQ_ENABLE: rd_byte = endpoint_en_q;
      REG_TIMER_COUNT_LOW: rd_byte = timer_count[7:0]; // [RQ9]
      REG_TIMER_COUNT_HIGH: rd_byte = timer_high_hold_q; // [RQ9]
      REG_IRQ_STATUS: rd_byte = 8'(pend_q);
      REG_IRQ_VECTOR: rd_byte = {4'h0, irq_o, irq_vector_o};
      default: bus_mapped = 1'b0;
    endcase
  end

  // Read data stands from the answer cycle until the next answer
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_capture) begin
      avs_readdata_o <= {24'h00_0000, bus_mapped ? rd_byte : 8'h00};
    end
  end

  // Low-byte read freezes the high nibble so two-byte reads agree
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      timer_high_hold_q <= 8'h00;
    end else if (rd_capture && reg_hit(req, REG_TIMER_COUNT_LOW)) begin
      timer_high_hold_q <= 8'(timer_count[TIMER_W-1:8]); // [RQ9]
    end
  end

  // Status read clears only the bits it returned; a source that fires between
  // capture and take stays pending for the next read
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_shown_q <= '0;
    end else if (rd_capture && reg_hit(req, REG_IRQ_STATUS)) begin
      status_shown_q <= pend_q;
    end
  end

  // Writable configuration
  // Read-only and unmapped indices ignore writes
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port0_en_q <= RST_PORT_ENABLE;
      port1_en_q <= RST_PORT_ENABLE;
      port0_pol_q <= RST_PORT_POLARITY;
      port1_pol_q <= RST_PORT_POLARITY;
      global_en_q <= RST_GLOBAL_ENABLE;
      endpoint_en_q <= RST_ENDPOINT_ENABLE;
    end else if (wr_take) begin
      case (req.index)
        REG_PORT0_IRQ_ENABLE: port0_en_q <= req.wdata;
        REG_PORT1_IRQ_ENABLE: port1_en_q <= req.wdata;
        REG_PORT0_IRQ_POLARITY: port0_pol_q <= req.wdata;
        REG_PORT1_IRQ_POLARITY: port1_pol_q <= req.wdata;
        REG_GLOBAL_IRQ_ENABLE: global_en_q <= req.wdata;
        REG_ENDPOINT_IRQ_ENABLE: endpoint_en_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // GPIO edge detection
  logic [P0_PINS-1:0] port0_prev_q;
  logic [P1_PINS-1:0] port1_prev_q;
  logic gpio_armed_q;
  logic gpio_event;

  // First sample after reset only primes the history
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port0_prev_q <= '0;
      port1_prev_q <= '0;
      gpio_armed_q <= 1'b0;
    end else begin
      port0_prev_q <= port0_pins_i;
      port1_prev_q <= port1_pins_i;
      gpio_armed_q <= 1'b1;
    end
  end

  // Pins share one request; edges in one cycle count once
  always_comb begin
    gpio_event = 1'b0;
    for (int i = 0; i < P0_PINS; i++) begin
      if (port0_en_q[i] && pin_edge(port0_pins_i[i], port0_prev_q[i], port0_pol_q[i])) begin
        gpio_event = gpio_armed_q; // [RQ6] [RQ7] [RQ8]
      end
    end
    for (int i = 0; i < P1_PINS; i++) begin
      if (port1_en_q[i] && pin_edge(port1_pins_i[i], port1_prev_q[i], port1_pol_q[i])) begin
        gpio_event = gpio_armed_q; // [RQ6] [RQ7] [RQ8]
      end
    end
  end

  // PS/2 activity: either idle-high line falling
  // Shares vector 0 with bus reset; both are ORed into the same pending bit at all times
  logic ps2_clk_prev_q;
  logic ps2_dat_prev_q;
  logic ps2_start;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ps2_clk_prev_q <= 1'b1;
      ps2_dat_prev_q <= 1'b1;
    end else begin
      ps2_clk_prev_q <= ps2_clock_line_i;
      ps2_dat_prev_q <= ps2_data_line_i;
    end
  end

  assign ps2_start = pin_edge(ps2_clock_line_i, ps2_clk_prev_q, 1'b0)
                   || pin_edge(ps2_data_line_i, ps2_dat_prev_q, 1'b0); // [RQ10]

  // Source gathering
  always_comb begin
    pend_set = '0;
    pend_set[SRC_BUS_RESET] = usb_bus_reset_i || ps2_start; // [RQ2] [RQ10]
    pend_set[SRC_TAP_FAST] = tap_fast; // [RQ4]
    pend_set[SRC_TAP_SLOW] = tap_slow; // [RQ4]
    pend_set[SRC_EP0] = ep0_done_i; // [RQ5]
    pend_set[SRC_EP1] = ep1_done_i; // [RQ5]
    pend_set[SRC_GPIO] = gpio_event; // [RQ6]
    pend_set[SRC_WAKEUP] = wakeup_i; // [RQ2]
  end

  // Global bits 3, 4 and 6 are unused
  always_comb begin
    src_en = '0;
    src_en[SRC_BUS_RESET] = global_en_q[GEN_BUS_RESET];
    src_en[SRC_TAP_FAST] = global_en_q[GEN_TAP_FAST];
    src_en[SRC_TAP_SLOW] = global_en_q[GEN_TAP_SLOW];
    src_en[SRC_EP0] = endpoint_en_q[EEN_EP0];
    src_en[SRC_EP1] = endpoint_en_q[EEN_EP1];
    src_en[SRC_GPIO] = global_en_q[GEN_GPIO];
    src_en[SRC_WAKEUP] = global_en_q[GEN_WAKEUP];
  end

  // Clears: acknowledge of a vector, or a read of the status register
  always_comb begin
    pend_clr = '0;
    // Vector 7 names no source and is ignored
    if (irq_ack_i && (32'(irq_ack_vector_i) < NUM_SRC)) begin
      pend_clr[irq_ack_vector_i] = 1'b1; // [RQ11]
    end
    if (bus_take && req.read && reg_hit(req, REG_IRQ_STATUS)) begin
      pend_clr = pend_clr | status_shown_q;
    end
  end

  // Disabled sources still latch, so enabling later exposes them
  // Set beats clear in the same cycle so no event is lost
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set; // [RQ11]
    end
  end

  assign live = pend_q & src_en; // [RQ1] [RQ11]

  // Presented one cycle after the pending state settles
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      irq_vector_o <= 3'h0;
    end else begin
      irq_o <= |live; // [RQ11]
      irq_vector_o <= pick_vector(live); // [RQ1]
    end
  end

endmodule // vit_irq_ctrl

// *** vit_irq_ctrl_chk.sv ***
// Port-level checks for the vectored interrupt controller.
// Assumes byteenable is all ones and only the top module's ports are seen.
`timescale 1ns/1ps
module vit_irq_ctrl_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Events and processor side
  input wire logic usb_bus_reset_i,
  input wire logic ep0_done_i,
  input wire logic irq_o,
  input wire logic [2:0] irq_vector_o
);
  logic [7:0] gen_q;
  logic [7:0] een_q;
  logic en_any;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Shadow of the enables, updated at the same taken edge as the design
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      gen_q <= 8'h00;
      een_q <= 8'h00;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      if (avs_address_i == 10'h080) gen_q <= avs_writedata_i[7:0];
      if (avs_address_i == 10'h084) een_q <= avs_writedata_i[7:0];
    end
  end
  assign en_any = |{gen_q[7], gen_q[5], gen_q[2:0], een_q[1:0]};
  a_wait_answers: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for two cycles");
  a_wait_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  a_data_upper: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_timer_high: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h094
    |-> avs_readdata_o[7:4] == 4'h0)
    else $error("timer high byte wider than four bits");
  a_vec_idle: assert property (!irq_o |-> irq_vector_o == 3'h0)
    else $error("vector nonzero without request");
  a_irq_enabled: assert property (irq_o |-> $past(en_any))
    else $error("request with no source enabled");
  a_busrst_irq: assert property (usb_bus_reset_i && gen_q[0] ##1 gen_q[0] |->
    ##1 (irq_o && irq_vector_o == 3'h0))
    else $error("bus reset did not raise vector 0");
  a_ep0_irq: assert property (ep0_done_i && een_q[0] ##1 een_q[0] |->
    ##1 (irq_o && irq_vector_o <= 3'h3))
    else $error("endpoint 0 did not raise its request");
endmodule // vit_irq_ctrl_chk
bind vit_irq_ctrl vit_irq_ctrl_chk u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .usb_bus_reset_i(usb_bus_reset_i),
  .ep0_done_i(ep0_done_i), .irq_o(irq_o), .irq_vector_o(irq_vector_o));

// *** vit_irq_ctrl_tb.sv ***
// Self-checking bench for the vectored interrupt controller and timer.
// Assumes vit_cpu_model acknowledges vectors while its run input is high.
`timescale 1ns/1ps
module vit_irq_ctrl_tb;
  import vit_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, run = 1'b0, ps2c = 1'b1, ps2d = 1'b1;
  logic ack, irq, wreq;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [3:0] src = 4'h0, dly = 4'h0;
  logic [7:0] p0 = 8'h00;
  logic [1:0] p1 = 2'h3;
  logic [2:0] vec, ackv;
  logic [11:0] t0, t1;
  logic [7:0] regs[6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h20, 8'h21};
  int fails = 0, checks_done = 0, cyc = 0;
  int acks[8] = '{default: 0};
  int base[8];
  always #25 clk = ~clk;
  vit_irq_ctrl uut (.core_clk_i(clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .usb_bus_reset_i(src[0]),
    .ep0_done_i(src[1]), .ep1_done_i(src[2]), .wakeup_i(src[3]), .port0_pins_i(p0),
    .port1_pins_i(p1), .ps2_clock_line_i(ps2c), .ps2_data_line_i(ps2d), .irq_ack_i(ack),
    .irq_ack_vector_i(ackv), .irq_o(irq), .irq_vector_o(vec));
  vit_cpu_model u_cpu (.core_clk_i(clk), .reset_i(rst), .run_i(run), .delay_i(dly),
    .irq_i(irq), .vector_i(vec), .ack_o(ack), .ack_vector_o(ackv));
  always @(posedge clk) if (ack) acks[ackv]++;
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge, released there
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    chk(wreq, 0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask
  task automatic fire(input logic [3:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic gp(input logic [7:0] a, input logic [1:0] b, input int n);
    @(posedge clk);
    base = acks;
    p0 <= a;
    p1 <= b;
    repeat (20) @(posedge clk);
    chk(acks[5] - base[5], n);
  endtask
  task automatic tm(output logic [11:0] t);
    bus(1'b0, 8'h24, 8'h00);
    t[7:0] = q[7:0];
    bus(1'b0, 8'h25, 8'h00);
    t[11:8] = q[3:0];
  endtask
  task automatic wack();
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(ack === 1'b1 && ackv === 3'h1) && n < 3000);
    chk({ack, ackv}, 32'h9);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) begin
      rr(regs[i], 0);
      bus(1'b1, regs[i], 8'h5A);
      rr(regs[i], 32'h5A);
      bus(1'b1, regs[i], 8'h00);
    end
    bus(1'b1, 8'h30, 8'hFF);
    rr(8'h30, 0);
    rr(8'h29, 0);
    bus(1'b0, 8'h28, 8'h00);
    fire(4'hF);
    chk(irq, 0);
    bus(1'b0, 8'h28, 8'h00);
    chk(q & 32'h59, 32'h59);
    bus(1'b0, 8'h28, 8'h00);
    chk(q & 32'h59, 0);
    bus(1'b1, 8'h20, 8'hA1);
    bus(1'b1, 8'h21, 8'h03);
    fire(4'hE);
    rr(8'h29, 32'h0B);
    base = acks;
    run <= 1'b1;
    repeat (40) @(posedge clk);
    chk(acks[3] - base[3], 1);
    chk(acks[4] - base[4], 1);
    chk(acks[6] - base[6], 1);
    base = acks;
    fire(4'h1);
    repeat (20) @(posedge clk);
    ps2d <= 1'b0;
    repeat (20) @(posedge clk);
    ps2d <= 1'b1;
    ps2c <= 1'b0;
    repeat (20) @(posedge clk);
    ps2c <= 1'b1;
    repeat (20) @(posedge clk);
    chk(acks[0] - base[0], 3);
    bus(1'b1, 8'h04, 8'h01);
    bus(1'b1, 8'h06, 8'h01);
    bus(1'b1, 8'h05, 8'h02);
    bus(1'b1, 8'h07, 8'h00);
    gp(8'h01, 2'h3, 1);
    gp(8'h03, 2'h3, 0);
    gp(8'h02, 2'h3, 0);
    gp(8'h02, 2'h1, 1);
    gp(8'h00, 2'h1, 0);
    bus(1'b1, 8'h06, 8'h00);
    gp(8'h01, 2'h1, 0);
    gp(8'h00, 2'h1, 1);
    // Read spacing totals 2000 clocks, one hundred timer ticks
    tm(t0);
    repeat (1994) @(posedge clk);
    tm(t1);
    t1 = t1 - t0;
    chk(t1, 100);
    dly <= 4'h9;
    bus(1'b1, 8'h20, 8'h06);
    // Second ack is phase aligned; a stale pending may give the first
    wack();
    wack();
    repeat (1280) @(posedge clk);
    base = acks;
    repeat (40960) @(posedge clk);
    chk(acks[1] - base[1], 16);
    chk(acks[2] - base[2], 2);
    summarize();
  end
endmodule // vit_irq_ctrl_tb

// *** vit_pkg.sv ***
// Package for the vectored interrupt controller and free-running timer.
// Assumes a single 20 MHz core clock and an Avalon-MM host with 32-bit data.
package vit_pkg;

  // Clock and timer rates
  localparam int unsigned CORE_CLK_HZ = 20_000_000;
  localparam int unsigned TIMER_TICK_HZ = 1_000_000;
  localparam int unsigned TICK_DIV = CORE_CLK_HZ / TIMER_TICK_HZ;
  localparam int unsigned TIMER_W = 12;
  // Tap periods in microseconds and their width in timer bits
  localparam int unsigned TAP_FAST_US = 128;
  localparam int unsigned TAP_SLOW_US = 1024;
  localparam int unsigned TAP_FAST_BITS = $clog2(TAP_FAST_US);
  localparam int unsigned TAP_SLOW_BITS = $clog2(TAP_SLOW_US);

  // Register indices; byte address is four times the index
  localparam logic [7:0] REG_PORT0_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] REG_PORT1_IRQ_ENABLE = 8'h05;
  localparam logic [7:0] REG_PORT0_IRQ_POLARITY = 8'h06;
  localparam logic [7:0] REG_PORT1_IRQ_POLARITY = 8'h07;
  localparam logic [7:0] REG_GLOBAL_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] REG_ENDPOINT_IRQ_ENABLE = 8'h21;
  localparam logic [7:0] REG_TIMER_COUNT_LOW = 8'h24;
  localparam logic [7:0] REG_TIMER_COUNT_HIGH = 8'h25;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h28;
  localparam logic [7:0] REG_IRQ_VECTOR = 8'h29;

  // Reset values
  localparam logic [7:0] RST_PORT_ENABLE = 8'h00;
  localparam logic [7:0] RST_PORT_POLARITY = 8'h00;
  localparam logic [7:0] RST_GLOBAL_ENABLE = 8'h00;
  localparam logic [7:0] RST_ENDPOINT_ENABLE = 8'h00;

  // Source numbers, also the vector index; lower number wins
  localparam int unsigned NUM_SRC = 7;
  localparam int unsigned SRC_BUS_RESET = 0;
  localparam int unsigned SRC_TAP_FAST = 1;
  localparam int unsigned SRC_TAP_SLOW = 2;
  localparam int unsigned SRC_EP0 = 3;
  localparam int unsigned SRC_EP1 = 4;
  localparam int unsigned SRC_GPIO = 5;
  localparam int unsigned SRC_WAKEUP = 6;

  // Bit positions in the global enable register
  localparam int unsigned GEN_BUS_RESET = 0;
  localparam int unsigned GEN_TAP_FAST = 1;
  localparam int unsigned GEN_TAP_SLOW = 2;
  localparam int unsigned GEN_GPIO = 5;
  localparam int unsigned GEN_WAKEUP = 7;
  // Bit positions in the endpoint enable register
  localparam int unsigned EEN_EP0 = 0;
  localparam int unsigned EEN_EP1 = 1;

  typedef logic [NUM_SRC-1:0] vit_src_t;

  // One bus request as seen by the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] index;
    logic aligned;
    logic [7:0] wdata;
  } vit_bus_req_t;

  // Bus slave states, Gray along idle -> answer
  typedef enum logic [1:0] {
    VIT_BUS_IDLE = 2'b00,
    VIT_BUS_ANSWER = 2'b01
  } vit_bus_state_t;

endpackage
